// ---- src/eeprom_page_access_controller.sv ----
`timescale 1ns/1ps
module eeprom_page_access_controller
  import eeprom_page_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              ADDR_WR_IN,
  input  wire logic [ADDR_W-1:0] ADDR_WDATA_IN,
  input  wire logic              DATA_WR_IN,
  input  wire logic [DATA_W-1:0] DATA_WDATA_IN,
  input  wire logic              DATA_RD_IN,
  input  wire logic              CTRL_WR_IN,
  input  wire logic [DATA_W-1:0] CTRL_WDATA_IN,
  input  wire logic              RELOAD_WR_IN,
  input  wire logic [DATA_W-1:0] RELOAD_WDATA_IN,
  output logic      [DATA_W-1:0] DATA_RDATA_OUT,
  output logic      [DATA_W-1:0] CTRL_RDATA_OUT,
  output logic      [ADDR_W-1:0] ADDR_OUT,
  output logic      [DATA_W-1:0] INTERVAL_OUT,
  output logic                   IRQ_OUT
);

  // start codes; write page ignores its lowest mode bit
  function automatic logic is_write_code(input logic [3:0] code);
    return (code & OP_WRITE_MASK) == OP_WRITE;
  endfunction

  function automatic logic is_start_code(input logic [3:0] code);
    return is_write_code(code) || code == OP_ERASE_WRITE ||
           code == OP_ERASE;
  endfunction

  // array index of one byte of the addressed page
  function automatic logic [ADDR_W-1:0] byte_index(
      input logic [PAGE_W-1:0] pg,
      input int                b);
    return {pg, SEL_W'(b)};
  endfunction

  logic [ADDR_W-1:0]     addr;
  logic [ADDR_W-1:0]     next_addr;
  logic                  incr_step;
  logic [DATA_W-1:0]     interval_reload_reg;
  logic                  interval_irq_enable;
  logic                  interval_flag;
  logic                  program_busy_bit;
  logic                  mode_bit_high;
  logic                  mode_bit_mid;
  logic                  mode_bit_low;
  logic [PAGE_BYTES-1:0] byte_update_flags;
  logic [DATA_W-1:0]     latch [PAGE_BYTES];
  logic [DATA_W-1:0]     array_mem [ARRAY_BYTES];
  cycle_state_e          state;
  cycle_state_e          next_state;

  logic [3:0]            ctrl_code;
  logic [3:0]            wr_code;
  logic                  idle;
  logic                  start_cycle;
  logic                  timer_expire;
  logic                  phase_end;
  logic                  cycle_done;
  logic                  erase_then_write;
  logic                  setup_write;
  logic                  read_access;
  logic [PAGE_W-1:0]     page;

  assign ctrl_code = {program_busy_bit, mode_bit_high, mode_bit_mid,
                      mode_bit_low};
  assign wr_code   = {CTRL_WDATA_IN[CTRL_BUSY_BIT],
                      CTRL_WDATA_IN[CTRL_MODE_H_BIT],
                      CTRL_WDATA_IN[CTRL_MODE_M_BIT],
                      CTRL_WDATA_IN[CTRL_MODE_L_BIT]};
  assign idle      = (state == ST_IDLE);
  assign page      = addr[ADDR_W-1:SEL_W];

  // an illegal code with busy set never starts anything
  assign start_cycle = CTRL_WR_IN && idle && is_start_code(wr_code);

  // combined cycle is the only one with a second phase
  assign erase_then_write = (ctrl_code == OP_ERASE_WRITE);
  assign phase_end  = timer_expire && !idle;
  assign cycle_done = phase_end &&
                      ((state == ST_WRITE) || !erase_then_write);

  // setup writes and read address steps are refused while a cycle runs
  assign setup_write = DATA_WR_IN && idle;
  assign read_access = DATA_RD_IN && idle && ctrl_code == OP_READ;

  // stepping past latch 3 would wrap onto latch 0 and merge its bits
  // into the wrong byte, so the subcounter saturates instead
  assign incr_step = setup_write && ctrl_code == OP_INCREMENT &&
                     addr[SEL_W-1:0] != LAST_LATCH;

  // ------------------------------------------------------------------
  // cycle sequencing
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_cycle && is_write_code(wr_code)) begin
          next_state = ST_WRITE;
        end else if (start_cycle) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (phase_end && erase_then_write) begin
          next_state = ST_WRITE;
        end else if (phase_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (phase_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // timer reload at the erase/write phase change happens inside the
  // timer itself; stop only after the last interval
  interval_timer u_interval_timer (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .load_in    (start_cycle),
    .stop_in    (cycle_done),
    .reload_in  (interval_reload_reg),
    .count_out  (INTERVAL_OUT),
    .expire_out (timer_expire)
  );

  // ------------------------------------------------------------------
  // control word
  // ------------------------------------------------------------------
  // busy and mode are frozen while a cycle runs
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      program_busy_bit <= 1'b0;
      mode_bit_high    <= 1'b0;
      mode_bit_mid     <= 1'b0;
      mode_bit_low     <= 1'b0;
    end else if (cycle_done) begin
      program_busy_bit <= 1'b0;
      mode_bit_high    <= 1'b0;
      mode_bit_mid     <= 1'b0;
      mode_bit_low     <= 1'b0;
    end else if (CTRL_WR_IN && idle) begin
      program_busy_bit <= start_cycle;
      mode_bit_high    <= CTRL_WDATA_IN[CTRL_MODE_H_BIT];
      mode_bit_mid     <= CTRL_WDATA_IN[CTRL_MODE_M_BIT];
      mode_bit_low     <= CTRL_WDATA_IN[CTRL_MODE_L_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      interval_irq_enable <= 1'b0;
    end else if (CTRL_WR_IN) begin
      interval_irq_enable <= CTRL_WDATA_IN[CTRL_IRQ_EN_BIT];
    end
  end

  // software may set or clear the flag; a cycle end in the same clock
  // wins so the completion is never lost
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      interval_flag <= 1'b0;
    end else if (cycle_done) begin
      interval_flag <= 1'b1;
    end else if (CTRL_WR_IN) begin
      interval_flag <= CTRL_WDATA_IN[CTRL_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      interval_reload_reg <= DATA_RESET;
    end else if (RELOAD_WR_IN) begin
      interval_reload_reg <= RELOAD_WDATA_IN;
    end
  end

  // ------------------------------------------------------------------
  // address register
  // ------------------------------------------------------------------
  // priority: cycle end, address write, read, latch step
  // an address write while busy is dropped, not queued, so a stray
  // write cannot redirect the page of a running cycle
  always_comb begin
    next_addr = addr;
    if (cycle_done) begin
      // plain +1 carries from byte 3 into the next page at byte 0
      if (ctrl_code != OP_ERASE) begin
        next_addr = addr + 1'b1;
      end
    end else if (ADDR_WR_IN && idle) begin
      next_addr = ADDR_WDATA_IN;
    end else if (read_access) begin
      next_addr = addr + 1'b1;
    end else if (incr_step) begin
      next_addr = {addr[ADDR_W-1:SEL_W],
                   addr[SEL_W-1:0] + 1'b1};
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      addr <= ADDR_RESET;
    end else begin
      addr <= next_addr;
    end
  end

  // ------------------------------------------------------------------
  // page latches and update flags
  // ------------------------------------------------------------------
  generate
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_latch
      logic hit;
      assign hit = setup_write &&
                   addr[SEL_W-1:0] == SEL_W'(i);

      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          latch[i] <= DATA_RESET;
        end else if (cycle_done) begin
          latch[i] <= DATA_RESET;
        end else if (hit) begin
          latch[i] <= latch[i] | DATA_WDATA_IN;
        end
      end

      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          byte_update_flags[i] <= 1'b0;
        end else if (cycle_done) begin
          byte_update_flags[i] <= 1'b0;
        end else if (hit) begin
          byte_update_flags[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // array; contents survive reset as a nonvolatile store would
  // ------------------------------------------------------------------
  // effects land at the end of each interval, so an aborted cycle
  // (reset mid-interval) leaves the page untouched by that interval
  // flags and latches are still intact at the erase phase end, since
  // only cycle_done or reset clears them; the write phase reuses them
  always_ff @(posedge CLK_IN) begin
    for (int b = 0; b < PAGE_BYTES; b++) begin
      if (phase_end && byte_update_flags[b]) begin
        if (state == ST_ERASE) begin
          array_mem[byte_index(page, b)] <= ERASED_BYTE;
        end else begin
          array_mem[byte_index(page, b)] <=
            array_mem[byte_index(page, b)] | latch[b];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      DATA_RDATA_OUT <= DATA_RESET;
    end else if (DATA_RD_IN) begin
      DATA_RDATA_OUT <= array_mem[addr];
    end
  end

  // status image; latches are never visible here
  // one cycle of lag: software polling busy sees the end one clock late
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CTRL_RDATA_OUT <= DATA_RESET;
    end else begin
      CTRL_RDATA_OUT <= DATA_RESET;
      CTRL_RDATA_OUT[CTRL_IRQ_EN_BIT] <= interval_irq_enable;
      CTRL_RDATA_OUT[CTRL_FLAG_BIT]   <= interval_flag;
      CTRL_RDATA_OUT[CTRL_BUSY_BIT]   <= program_busy_bit;
      CTRL_RDATA_OUT[CTRL_MODE_H_BIT] <= mode_bit_high;
      CTRL_RDATA_OUT[CTRL_MODE_M_BIT] <= mode_bit_mid;
      CTRL_RDATA_OUT[CTRL_MODE_L_BIT] <= mode_bit_low;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ADDR_OUT <= ADDR_RESET;
      IRQ_OUT  <= 1'b0;
    end else begin
      ADDR_OUT <= addr;
      IRQ_OUT  <= interval_flag && interval_irq_enable;
    end
  end

endmodule // eeprom_page_access_controller

// ---- src/eeprom_page_pkg.sv ----
package eeprom_page_pkg;

  // array geometry
  localparam int ADDR_W      = 7;
  localparam int PAGE_W      = 5;
  localparam int SEL_W       = 2;
  localparam int DATA_W      = 8;
  localparam int PAGE_BYTES  = 4;
  localparam int ARRAY_BYTES = 128;

  // control word bit positions
  localparam int CTRL_IRQ_EN_BIT = 6;
  localparam int CTRL_FLAG_BIT   = 5;
  localparam int CTRL_BUSY_BIT   = 4;
  localparam int CTRL_MODE_H_BIT = 3;
  localparam int CTRL_MODE_M_BIT = 2;
  localparam int CTRL_MODE_L_BIT = 1;

  // operation codes as {busy, mode_high, mode_mid, mode_low}
  localparam logic [3:0] OP_READ        = 4'h0;
  localparam logic [3:0] OP_INCREMENT   = 4'h2;
  localparam logic [3:0] OP_WRITE       = 4'ha;
  localparam logic [3:0] OP_WRITE_MASK  = 4'he;
  localparam logic [3:0] OP_ERASE_WRITE = 4'hc;
  localparam logic [3:0] OP_ERASE       = 4'hf;

  // reset and fill values
  localparam logic [ADDR_W-1:0] ADDR_RESET   = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] ERASED_BYTE  = 8'h00;
  localparam logic [SEL_W-1:0]  LAST_LATCH   = 2'h3;

  // interval counter timing
  localparam int          PRESCALE_DIV = 480;
  localparam int          PRESCALE_W   = 9;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
    PRESCALE_W'(PRESCALE_DIV - 1);
  localparam int          CLK_HZ       = 50_000_000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b11
  } cycle_state_e;

endpackage

// ---- src/interval_timer.sv ----
`timescale 1ns/1ps
module interval_timer
  import eeprom_page_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              load_in,
  input  wire logic              stop_in,
  input  wire logic [DATA_W-1:0] reload_in,
  output logic      [DATA_W-1:0] count_out,
  output logic                   expire_out
);

  logic [PRESCALE_W-1:0] prescale;
  logic                  running;
  logic                  tick;

  assign tick = running && (prescale == PRESCALE_LAST);

  // one decrement every 480 clocks
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prescale <= '0;
    end else if (load_in || !running || tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      running <= 1'b0;
    end else if (load_in) begin
      running <= 1'b1;
    end else if (stop_in) begin
      running <= 1'b0;
    end
  end

  // underflow from zero reloads, so a second phase needs no extra load
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_out  <= DATA_RESET;
      expire_out <= 1'b0;
    end else begin
      expire_out <= tick && (count_out == DATA_RESET);
      if (load_in) begin
        count_out <= reload_in;
      end else if (tick && count_out == DATA_RESET) begin
        count_out <= reload_in;
      end else if (tick) begin
        count_out <= count_out - 1'b1;
      end
    end
  end

endmodule // interval_timer

// ---- test/eeprom_page_properties.sv ----
`timescale 1ns/1ps
module eeprom_page_properties
  import eeprom_page_pkg::*;
(
  input wire logic              CLK_IN,
  input wire logic              RSTN_IN,
  input wire logic              ADDR_WR_IN,
  input wire logic              DATA_WR_IN,
  input wire logic              DATA_RD_IN,
  input wire logic              CTRL_WR_IN,
  input wire logic [DATA_W-1:0] CTRL_WDATA_IN,
  input wire logic [DATA_W-1:0] CTRL_RDATA_OUT,
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic [DATA_W-1:0] INTERVAL_OUT,
  input wire logic              IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic       busy;
  logic [3:0] img;
  logic [3:0] code;
  assign busy = CTRL_RDATA_OUT[CTRL_BUSY_BIT];
  assign img  = CTRL_RDATA_OUT[4:1];
  assign code = CTRL_WDATA_IN[4:1];
  a_write_start: assert property (CTRL_WR_IN && !busy &&
    (code & OP_WRITE_MASK) == OP_WRITE |-> ##[1:3] busy)
    else $error("write page not started");
  a_combo_start: assert property (CTRL_WR_IN && !busy &&
    code == OP_ERASE_WRITE |-> ##[1:3] busy)
    else $error("erase/write not started");
  a_erase_start: assert property (CTRL_WR_IN && !busy &&
    code == OP_ERASE |-> ##[1:3] busy)
    else $error("erase page not started");
  a_bad_code: assert property (CTRL_WR_IN && !busy &&
    code inside {4'h9, 4'hd, 4'he} |=> !busy [*3])
    else $error("illegal code started a cycle");
  a_end_flags: assert property ($fell(busy) |->
    CTRL_RDATA_OUT[CTRL_FLAG_BIT] && img[2:0] == 3'h0)
    else $error("cycle end left mode bits or no flag");
  // the load lands one cycle before the busy image shows it
  a_counter_quiet: assert property ($changed(INTERVAL_OUT) |->
    ##[0:2] busy)
    else $error("interval counter moved while idle");
  a_irq_on: assert property ((CTRL_RDATA_OUT[6] &&
    CTRL_RDATA_OUT[5]) [*2] |-> IRQ_OUT)
    else $error("request missing with flag and enable");
  a_read_step: assert property (DATA_RD_IN && !ADDR_WR_IN &&
    img == OP_READ |-> ##2 ADDR_OUT == $past(ADDR_OUT, 2) + 7'h01)
    else $error("read did not advance address");
  a_incr_step: assert property (DATA_WR_IN && img == OP_INCREMENT |->
    ##2 ADDR_OUT == ((($past(ADDR_OUT, 2) & 7'h03) == 7'h03) ?
    $past(ADDR_OUT, 2) : $past(ADDR_OUT, 2) + 7'h01))
    else $error("latch select stepped wrongly");
  a_setup_hold: assert property (DATA_WR_IN && img == OP_READ |->
    ##2 ADDR_OUT == $past(ADDR_OUT, 2))
    else $error("setup write moved address");
endmodule // eeprom_page_properties

bind eeprom_page_access_controller eeprom_page_properties i_props (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_WR_IN(ADDR_WR_IN),
  .DATA_WR_IN(DATA_WR_IN), .DATA_RD_IN(DATA_RD_IN), .CTRL_WR_IN(CTRL_WR_IN),
  .CTRL_WDATA_IN(CTRL_WDATA_IN), .CTRL_RDATA_OUT(CTRL_RDATA_OUT),
  .ADDR_OUT(ADDR_OUT), .INTERVAL_OUT(INTERVAL_OUT), .IRQ_OUT(IRQ_OUT));

// ---- test/core_model.sv ----
`timescale 1ns/1ps
module core_model
  import eeprom_page_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [DATA_W-1:0] ctrl_in,
  input  wire logic [DATA_W-1:0] rdata_in,
  output logic      [3:0]        wr_out,
  output logic                   rd_out,
  output logic      [DATA_W-1:0] wdata_out
);
  initial begin
    wr_out    = 4'h0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end
  // k: 0 address, 1 data, 2 control, 3 reload; bus is junk once released
  task automatic put(input int k, input logic [DATA_W-1:0] v);
    @(negedge clk_in);
    wr_out[k] = 1'b1;
    wdata_out = v;
    @(negedge clk_in);
    wr_out    = 4'h0;
    wdata_out = ~v;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic get(output logic [DATA_W-1:0] v);
    @(negedge clk_in);
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    @(negedge clk_in);
    v = rdata_in;
  endtask
  // no new access while a cycle runs
  task automatic wait_idle(output int n);
    n = 0;
    while (ctrl_in[CTRL_BUSY_BIT] === 1'b1 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
  endtask
endmodule // core_model

// ---- test/eeprom_page_access_controller_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  n_fail++; $display("wrong value at %0t: %s", $time, m); end end
module eeprom_page_access_controller_tb_top import eeprom_page_pkg::*;;
  logic              clk, rstn, rd, irq;
  logic [3:0]        wr;
  logic [DATA_W-1:0] wd, rdata, ctrl, ivl;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] mem [4];
  logic [DATA_W-1:0] lat [4];
  int                n_fail;
  int                check_count;
  eeprom_page_access_controller i_eeprom_page_access_controller (
    .CLK_IN(clk), .RSTN_IN(rstn), .ADDR_WR_IN(wr[0]),
    .ADDR_WDATA_IN(wd[ADDR_W-1:0]), .DATA_WR_IN(wr[1]), .DATA_WDATA_IN(wd),
    .DATA_RD_IN(rd), .CTRL_WR_IN(wr[2]), .CTRL_WDATA_IN(wd),
    .RELOAD_WR_IN(wr[3]), .RELOAD_WDATA_IN(wd), .DATA_RDATA_OUT(rdata),
    .CTRL_RDATA_OUT(ctrl), .ADDR_OUT(addr), .INTERVAL_OUT(ivl),
    .IRQ_OUT(irq));
  core_model i_core_model (.clk_in(clk), .ctrl_in(ctrl), .rdata_in(rdata),
    .wr_out(wr), .rd_out(rd), .wdata_out(wd));
  // op 0 write, 1 erase, 2 erase/write
  function automatic logic [DATA_W-1:0] new_byte(input int op,
      input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] l);
    return (op == 0) ? (old | l) : (op == 1) ? ERASED_BYTE : l;
  endfunction
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic run(input logic [DATA_W-1:0] w, input int k,
      input int op, input logic [3:0] f, input logic [DATA_W-1:0] rl);
    int n;
    int e;
    i_core_model.put(3, rl);
    i_core_model.put(2, w);
    i_core_model.wait_idle(n);
    e = k * (int'(rl) + 1) * PRESCALE_DIV;
    `CHK(n inside {[e - 4:e + 6]}, 1'b1, "cycle length")
    `CHK(ctrl[CTRL_FLAG_BIT], 1'b1, "end flag")
    for (int i = 0; i < 4; i++) begin
      if (f[i]) mem[i] = new_byte(op, mem[i], lat[i]);
      lat[i] = 8'h00;
    end
  endtask
  task automatic vpage(input logic [4:0] pg);
    logic [DATA_W-1:0] v;
    i_core_model.put(0, {1'b0, pg, 2'h0});
    for (int i = 0; i < 4; i++) begin
      i_core_model.get(v);
      `CHK(v, mem[i], "page byte")
    end
    `CHK(addr, {pg + 5'h01, 2'h0}, "read address")
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin : main
    logic [4:0]        pg;
    logic [DATA_W-1:0] rl, v;
    logic [DATA_W-1:0] bad [3];
    rstn = 1'b0;
    n_fail = 0;
    check_count = 0;
    bad = '{8'h12, 8'h1a, 8'h1c};
    v = 8'($urandom(32'hf58f));
    pg = 5'($urandom);
    rl = 8'($urandom_range(1));
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    `CHK({ctrl, addr, ivl, irq, rdata}, 32'h0, "reset state")
    // setup on another page: only the select bits matter
    i_core_model.put(2, 8'h04);
    i_core_model.put(0, {1'b0, ~pg, 2'h0});
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      i_core_model.put(1, v);
      if (i < 4) lat[i] = v; else lat[3] |= v;
    end
    `CHK(addr, {~pg, 2'h3}, "select stops at last")
    i_core_model.put(0, {1'b0, pg, 2'h3});
    run(8'h18, 2, 2, 4'hf, rl);
    `CHK(addr, {pg + 5'h01, 2'h0}, "address to next page")
    vpage(pg);
    // erase two bytes; latch data must not matter
    for (int i = 0; i < 4; i += 2) begin
      i_core_model.put(0, {1'b0, pg, 2'(i)});
      i_core_model.put(1, 8'($urandom));
    end
    run(8'h1e, 1, 1, 4'h5, rl);
    `CHK(addr, {pg, 2'h2}, "erase keeps address")
    vpage(pg);
    // stale latch bits would show in the erased byte
    i_core_model.put(0, {1'b0, pg, 2'h0});
    v = 8'($urandom);
    lat[0] = v;
    i_core_model.put(1, v);
    `CHK(addr, {pg, 2'h0}, "setup keeps address")
    // write page with its don't-care mode bit set
    run(8'h56, 1, 0, 4'h1, rl);
    `CHK(addr, {pg, 2'h1}, "address after write")
    `CHK(irq, 1'b1, "end request")
    i_core_model.put(2, 8'h40);
    `CHK(irq, 1'b0, "request cleared")
    vpage(pg);
    // leftover latch or flag bits from earlier cycles would show here
    i_core_model.put(0, {1'b0, pg, 2'h3});
    v = 8'($urandom);
    lat[3] = v;
    i_core_model.put(1, v);
    run(8'h18, 2, 2, 4'h8, rl);
    vpage(pg);
    foreach (bad[i]) begin
      i_core_model.put(2, bad[i]);
      `CHK(ctrl[CTRL_BUSY_BIT], 1'b0, "bad code refused")
    end
    i_core_model.put(2, 8'h00);
    i_core_model.put(0, 8'h7f);
    i_core_model.get(v);
    `CHK(addr, 7'h00, "read wraps")
    end_sim();
  end
endmodule // eeprom_page_access_controller_tb_top
